// >>> rtl/fald_decode.sv
// decode, trap check and register write-back for float loads from alternate space
// assumes issue and memory path share sys_clk; one load is in flight at a time
//
// Implementation choices: the register offsets and the plain strobed port.
module fald_decode
  import fald_pkg::*;
#(
  parameter int ADDR_W = 64 // effective address width
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  // issue side
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [ADDR_W-1:0] first_source_value,
  input wire logic [ADDR_W-1:0] second_source_value,
  input wire logic [7:0] space_state_reg,
  input wire logic supervisor_flag,
  input wire logic float_status_enable,
  input wire logic state_float_enable,
  input wire logic extension_prefix_valid,
  input wire logic extension_vector_bit,
  input wire logic [2:0] first_source_extension,
  input wire logic [2:0] second_source_extension,
  input wire logic [2:0] third_source_extension,
  input wire logic [2:0] destination_extension,
  output logic issue_ready,
  output logic trap_valid,
  output fald_trap_e trap_code,
  // memory side
  output logic mem_req_valid,
  output logic [ADDR_W-1:0] mem_req_addr,
  output logic [7:0] mem_req_space,
  output logic [1:0] mem_req_size,
  output logic mem_req_priv,
  output logic mem_req_phys,
  output logic mem_req_little,
  input wire logic mem_resp_valid,
  input wire logic mem_resp_error,
  input wire logic [63:0] mem_resp_low_data,
  input wire logic [63:0] mem_resp_high_data,
  // float register write-back, two ports for the even/odd pair
  output logic fpr_wr_en,
  output logic [7:0] fpr_wr_index,
  output logic [63:0] fpr_wr_data,
  output logic [1:0] fpr_wr_size,
  output logic fpr_wr2_en,
  output logic [7:0] fpr_wr2_index,
  output logic [63:0] fpr_wr2_data
);

  // all state of the block
  typedef struct packed {
    fald_state_e st; // sequencing state
    logic ready; // can take an issue
    logic trap_valid; // one-cycle trap report
    fald_trap_e trap_code; // reported trap
    logic req_valid; // one-cycle memory request
    logic [ADDR_W-1:0] req_addr; // effective address
    logic [7:0] req_space; // selected address space
    logic [1:0] req_size; // access size
    logic req_priv; // privileged access
    logic req_phys; // physically addressed
    logic req_little; // little-endian order
    logic [7:0] dest; // destination register number
    logic wr_en; // first write port strobe
    logic [7:0] wr_idx; // first write port index
    logic [63:0] wr_data; // first write port data
    logic wr2_en; // second write port strobe
    logic [7:0] wr2_idx; // second write port index
    logic [63:0] wr2_data; // second write port data
  } fald_state_s;

  fald_state_s s_q;
  fald_state_s s_d;

  // instruction fields
  logic [1:0] f_op;
  logic [5:0] f_sub;
  logic [4:0] f_rd;
  logic [4:0] f_rs1;
  logic [4:0] f_rs2;
  logic f_imm;
  logic [7:0] f_asi;
  logic [12:0] signed_offset_field;

  assign f_op = issue_instr[FALD_POS_OP +: 2];
  assign f_sub = issue_instr[FALD_POS_SUB +: 6];
  assign f_rd = issue_instr[FALD_POS_RD +: 5];
  assign f_rs1 = issue_instr[FALD_POS_RS1 +: 5];
  assign f_rs2 = issue_instr[FALD_POS_RS2 +: 5];
  assign f_imm = issue_instr[FALD_POS_I];
  assign f_asi = issue_instr[FALD_POS_ASI +: 8];
  assign signed_offset_field = issue_instr[12:0];

  // decoded kinds
  logic alt_single_float_load;
  logic alt_double_float_load;
  logic alt_quad_float_load;
  logic quad_atomic;
  logic [7:0] space;
  logic [ADDR_W-1:0] eff_addr;
  logic [3:0] low_addr;
  logic prefix_bad;
  logic unit_off;
  logic priv_space;

  always_comb
  begin
    // recognise each opcode subfield only under the memory major field
    alt_single_float_load = (f_op == FALD_OP_MEM) && (f_sub == FALD_SUB_SINGLE);
    alt_double_float_load = (f_op == FALD_OP_MEM) && (f_sub == FALD_SUB_DOUBLE);
    alt_quad_float_load = (f_op == FALD_OP_MEM) && (f_sub == FALD_SUB_QUAD);
    // space from the immediate field or from the state register
    space = f_imm ? space_state_reg : f_asi;
    // effective address, offset sign-extended to full width
    if (f_imm)
    begin
      eff_addr = first_source_value
               + {{(ADDR_W-13){signed_offset_field[12]}}, signed_offset_field};
    end
    else
    begin
      eff_addr = first_source_value + second_source_value;
    end
    low_addr = eff_addr[3:0];
    quad_atomic = alt_double_float_load
                && ((space == FALD_QUAD_ATOMIC_PHYS_SPACE)
                 || (space == FALD_QUAD_ATOMIC_PHYS_SPACE_LITTLE));
    // bit 7 clear marks a privileged space
    priv_space = ~space[FALD_POS_SPACE_PRIV];
    unit_off = ~float_status_enable | ~state_float_enable;
    // extension prefix limits on source and destination fields
    prefix_bad = extension_prefix_valid
               && ((first_source_extension > 3'h1)
                || (!f_imm && (second_source_extension > 3'h1))
                || (f_imm && (second_source_extension != 3'h0))
                || third_source_extension[2]);
    if (extension_prefix_valid && extension_vector_bit && destination_extension[2])
    begin
      prefix_bad = 1'b1;
    end
  end

  // trap selection by fixed priority: only the first hit is reported
  fald_trap_e trap_sel;

  always_comb
  begin
    trap_sel = FALD_TRAP_NONE;
    if (alt_quad_float_load)
    begin
      // not implemented: unit-off is deliberately not looked at here
      trap_sel = FALD_TRAP_ILLEGAL_INSTR;
    end
    else if (quad_atomic && f_rd[0])
    begin
      trap_sel = FALD_TRAP_ILLEGAL_INSTR; // odd pair base
    end
    else if (unit_off)
    begin
      trap_sel = FALD_TRAP_UNIT_OFF;
    end
    else if (prefix_bad || (quad_atomic && extension_prefix_valid && extension_vector_bit))
    begin
      trap_sel = FALD_TRAP_ILLEGAL_ACTION;
    end
    else if (!supervisor_flag && priv_space)
    begin
      trap_sel = FALD_TRAP_PRIV_ACTION;
    end
    else if (quad_atomic)
    begin
      if ((low_addr & FALD_MASK_QWORD) != 4'h0)
      begin
        trap_sel = FALD_TRAP_MISALIGN;
      end
    end
    else if (alt_double_float_load)
    begin
      if ((low_addr & FALD_MASK_WORD) != 4'h0)
      begin
        trap_sel = FALD_TRAP_MISALIGN;
      end
      else if (((low_addr & FALD_MASK_DWORD) != 4'h0)
            && (!extension_prefix_valid || !extension_vector_bit))
      begin
        trap_sel = FALD_TRAP_DOUBLE_MISALIGN;
      end
      else if ((low_addr & FALD_MASK_DWORD) != 4'h0)
      begin
        trap_sel = FALD_TRAP_MISALIGN; // vector double needs 8-byte alignment
      end
    end
    else if ((low_addr & FALD_MASK_WORD) != 4'h0)
    begin
      trap_sel = FALD_TRAP_MISALIGN;
    end
  end

  // next-state logic for the whole block
  always_comb
  begin
    s_d = s_q;
    // pulses last one cycle
    s_d.trap_valid = 1'b0;
    s_d.req_valid = 1'b0;
    s_d.wr_en = 1'b0;
    s_d.wr2_en = 1'b0;
    case (s_q.st)
      FALD_ST_IDLE:
      begin
        if (issue_valid && (alt_single_float_load || alt_double_float_load
                            || alt_quad_float_load))
        begin
          if (trap_sel != FALD_TRAP_NONE)
          begin
            // a trapping load never reaches memory nor the register file
            s_d.trap_valid = 1'b1;
            s_d.trap_code = trap_sel;
          end
          else
          begin
            s_d.req_valid = 1'b1;
            s_d.req_addr = eff_addr;
            s_d.req_space = space;
            s_d.req_priv = priv_space;
            s_d.req_phys = quad_atomic;
            s_d.req_little = quad_atomic && (space == FALD_QUAD_ATOMIC_PHYS_SPACE_LITTLE);
            if (quad_atomic)
            begin
              s_d.req_size = FALD_SIZE_QWORD;
            end
            else if (alt_double_float_load)
            begin
              s_d.req_size = FALD_SIZE_DWORD;
            end
            else
            begin
              s_d.req_size = FALD_SIZE_WORD;
            end
            s_d.dest = {destination_extension, f_rd};
            s_d.ready = 1'b0;
            s_d.st = FALD_ST_WAIT;
          end
        end
      end
      FALD_ST_WAIT:
      begin
        if (mem_resp_valid)
        begin
          s_d.ready = 1'b1;
          s_d.st = FALD_ST_IDLE;
          if (mem_resp_error)
          begin
            // destination left untouched on an access error
            s_d.trap_valid = 1'b1;
            s_d.trap_code = FALD_TRAP_ACCESS_ERROR;
          end
          else
          begin
            s_d.wr_en = 1'b1;
            s_d.wr_idx = s_q.dest;
            if (s_q.req_size == FALD_SIZE_WORD)
            begin
              s_d.wr_data = {32'h0000_0000, mem_resp_low_data[31:0]};
            end
            else
            begin
              s_d.wr_data = mem_resp_low_data;
            end
            if (s_q.req_size == FALD_SIZE_QWORD)
            begin
              // lower-addressed half to even, higher-addressed half to odd
              s_d.wr_idx = {s_q.dest[7:1], 1'b0};
              s_d.wr2_en = 1'b1;
              s_d.wr2_idx = {s_q.dest[7:1], 1'b1};
              s_d.wr2_data = mem_resp_high_data;
            end
          end
        end
      end
      default:
      begin
        s_d.st = FALD_ST_IDLE;
        s_d.ready = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // every output straight from the state register
  assign issue_ready = s_q.ready;
  assign trap_valid = s_q.trap_valid;
  assign trap_code = s_q.trap_code;
  assign mem_req_valid = s_q.req_valid;
  assign mem_req_addr = s_q.req_addr;
  assign mem_req_space = s_q.req_space;
  assign mem_req_size = s_q.req_size;
  assign mem_req_priv = s_q.req_priv;
  assign mem_req_phys = s_q.req_phys;
  assign mem_req_little = s_q.req_little;
  assign fpr_wr_en = s_q.wr_en;
  assign fpr_wr_index = s_q.wr_idx;
  assign fpr_wr_data = s_q.wr_data;
  assign fpr_wr_size = s_q.req_size;
  assign fpr_wr2_en = s_q.wr2_en;
  assign fpr_wr2_index = s_q.wr2_idx;
  assign fpr_wr2_data = s_q.wr2_data;

endmodule : fald_decode

// >>> shared/fald_pkg.sv
// constants, types and trap encodings for the alternate-space float load decoder
// assumes one core clock domain; issue side and memory side are synchronous to it
// Notes on behaviour
// - decode single, double, quad alternate opcode subfields
// - single word, double doubleword, quad quad-precision
// - space from immediate field or state register
// - address sum of sources or signed offset
// - space bit 7 zero means privileged access
// - single/double privileged space from user traps
// - single load needs four-byte aligned address
// - either float enable clear gives unit-off trap
// - double at 4 not 8 aligned traps
// - that trap only without vector prefix
// - quad always illegal, unit-off not checked
// - access error leaves float register unchanged
// - prefix source extension limits give illegal action
// - vector prefix needs destination extension bit2 clear
// - double with quad spaces: atomic physical 128-bit
// - lower half even register, upper half odd
// - atomic quad needs sixteen-byte aligned address
package fald_pkg;

  // instruction major field and opcode subfield values
  localparam logic [1:0] FALD_OP_MEM = 2'h3;
  localparam logic [5:0] FALD_SUB_SINGLE = 6'h30; // 11 0000
  localparam logic [5:0] FALD_SUB_DOUBLE = 6'h33; // 11 0011
  localparam logic [5:0] FALD_SUB_QUAD = 6'h32; // 11 0010

  // instruction field positions
  localparam int FALD_POS_OP = 30;
  localparam int FALD_POS_RD = 25;
  localparam int FALD_POS_SUB = 19;
  localparam int FALD_POS_RS1 = 14;
  localparam int FALD_POS_I = 13;
  localparam int FALD_POS_ASI = 5;
  localparam int FALD_POS_RS2 = 0;
  localparam int FALD_POS_SPACE_PRIV = 7;

  // address spaces of the atomic physical quad load
  localparam logic [7:0] FALD_QUAD_ATOMIC_PHYS_SPACE = 8'h34;
  localparam logic [7:0] FALD_QUAD_ATOMIC_PHYS_SPACE_LITTLE = 8'h3C;

  // alignment masks on the low address bits
  localparam logic [3:0] FALD_MASK_WORD = 4'h3;
  localparam logic [3:0] FALD_MASK_DWORD = 4'h7;
  localparam logic [3:0] FALD_MASK_QWORD = 4'hF;

  // access sizes sent to the memory path
  localparam logic [1:0] FALD_SIZE_WORD = 2'h0;
  localparam logic [1:0] FALD_SIZE_DWORD = 2'h1;
  localparam logic [1:0] FALD_SIZE_QWORD = 2'h2;

  // trap codes, listed from highest to lowest priority, except FALD_TRAP_MISALIGN wins over FALD_TRAP_DOUBLE_MISALIGN
  typedef enum logic [2:0] {
    FALD_TRAP_NONE,
    FALD_TRAP_ILLEGAL_INSTR,
    FALD_TRAP_UNIT_OFF,
    FALD_TRAP_ILLEGAL_ACTION,
    FALD_TRAP_PRIV_ACTION,
    FALD_TRAP_DOUBLE_MISALIGN,
    FALD_TRAP_MISALIGN,
    FALD_TRAP_ACCESS_ERROR
  } fald_trap_e;

  // decoder sequencing
  typedef enum logic [0:0] {
    FALD_ST_IDLE,
    FALD_ST_WAIT
  } fald_state_e;

endpackage : fald_pkg

// >>> verification/fald_decode_props.sv
// assertions on the alternate-space float load decoder ports
// bound into fald_decode; one clock, async reset
module fald_decode_props
  import fald_pkg::*;
#(
  parameter int ADDR_W = 64
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic issue_valid,
  input wire logic [31:0] issue_instr,
  input wire logic [ADDR_W-1:0] first_source_value,
  input wire logic [ADDR_W-1:0] second_source_value,
  input wire logic [7:0] space_state_reg,
  input wire logic supervisor_flag,
  input wire logic float_status_enable,
  input wire logic state_float_enable,
  input wire logic extension_prefix_valid,
  input wire logic issue_ready,
  input wire logic trap_valid,
  input wire fald_trap_e trap_code,
  input wire logic mem_req_valid,
  input wire logic [ADDR_W-1:0] mem_req_addr,
  input wire logic [7:0] mem_req_space,
  input wire logic mem_req_priv,
  input wire logic mem_resp_valid,
  input wire logic mem_resp_error,
  input wire logic fpr_wr_en
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] sp; // selected space
  logic [ADDR_W-1:0] ea; // effective address
  logic tk; // word taken this edge
  logic sg; // single load with unit on, no prefix
  assign sp = issue_instr[13] ? space_state_reg : issue_instr[12:5];
  assign ea = first_source_value + (issue_instr[13] ?
    {{(ADDR_W-13){issue_instr[12]}}, issue_instr[12:0]} : second_source_value);
  assign tk = issue_valid && issue_ready && issue_instr[31:30] == FALD_OP_MEM;
  assign sg = tk && issue_instr[24:19] == FALD_SUB_SINGLE && float_status_enable
    && state_float_enable && !extension_prefix_valid;

  quad_illegal_a: assert property (
    tk && issue_instr[24:19] == FALD_SUB_QUAD |=> trap_valid
    && trap_code == FALD_TRAP_ILLEGAL_INSTR) else $error("quad not refused");
  unit_off_a: assert property (
    tk && issue_instr[24:19] == FALD_SUB_SINGLE && !(float_status_enable
    && state_float_enable) |=> trap_code == FALD_TRAP_UNIT_OFF) else $error("unit off missed");
  priv_trap_a: assert property (
    sg && !supervisor_flag && !sp[7] |=> trap_valid && trap_code == FALD_TRAP_PRIV_ACTION)
    else $error("privileged trap missed");
  single_align_a: assert property (
    sg && (supervisor_flag || sp[7]) && ea[1:0] != 2'h0 |=> trap_code == FALD_TRAP_MISALIGN)
    else $error("single misalign missed");
  req_fields_a: assert property (
    sg && (supervisor_flag || sp[7]) && ea[1:0] == 2'h0 |=> mem_req_valid && !issue_ready
    && mem_req_addr == $past(ea) && mem_req_space == $past(sp)) else $error("bad request");
  req_priv_a: assert property (
    mem_req_valid |-> mem_req_priv == !mem_req_space[7]) else $error("bad privilege");
  err_nowrite_a: assert property (
    mem_resp_valid && mem_resp_error && !issue_ready |=> !fpr_wr_en && trap_valid
    && trap_code == FALD_TRAP_ACCESS_ERROR) else $error("write after error");
  one_answer_a: assert property (
    !(trap_valid && mem_req_valid)) else $error("trap with request");
endmodule : fald_decode_props

bind fald_decode fald_decode_props #(.ADDR_W(ADDR_W)) fald_decode_props_i (.*);

// >>> verification/fald_mem_model.sv
// memory path stand-in: answers each request after lat+1 cycles; lat 15 wraps the count to 0 and never answers
// assumes one request outstanding, shares sys_clk with the decoder
module fald_mem_model
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mem_req_valid,
  input wire logic [63:0] mem_req_addr,
  input wire logic [3:0] lat,
  input wire logic err,
  output logic mem_resp_valid,
  output logic mem_resp_error,
  output logic [63:0] mem_resp_low_data,
  output logic [63:0] mem_resp_high_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q; // cycles to the answer, 0 when idle
  logic [63:0] addr_q; // pending address
  // outside the answer and the request edge the data toggle, so stale data never passes
  always @(posedge sys_clk or posedge sys_rst)
  begin
    mem_resp_valid <= 1'b0;
    mem_resp_error <= 1'b0;
    if (sys_rst)
    begin
      cnt_q <= 4'h0;
      mem_resp_low_data <= 64'h0;
      mem_resp_high_data <= 64'h0;
    end
    else if (mem_req_valid)
    begin
      cnt_q <= lat + 4'h1;
      addr_q <= mem_req_addr;
    end
    else if (cnt_q == 4'h1)
    begin
      cnt_q <= 4'h0;
      mem_resp_valid <= 1'b1;
      mem_resp_error <= err;
      mem_resp_low_data <= addr_q + 64'h11;
      mem_resp_high_data <= ~addr_q;
    end
    else
    begin
      cnt_q <= cnt_q - {3'h0, cnt_q != 4'h0};
      mem_resp_low_data <= ~mem_resp_low_data;
      mem_resp_high_data <= ~mem_resp_high_data;
    end
  end
endmodule : fald_mem_model

// >>> verification/test_fald_decode.sv
// self-checking bench for the alternate-space float load decoder
// issue side driven by tasks; memory side is fald_mem_model
module test_fald_decode
  import fald_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic issue_valid, supervisor_flag, float_status_enable, state_float_enable, err;
  logic extension_prefix_valid, extension_vector_bit, issue_ready, trap_valid;
  logic [31:0] issue_instr;
  logic [63:0] first_source_value, second_source_value, mem_req_addr;
  logic [63:0] mem_resp_low_data, mem_resp_high_data, fpr_wr_data, fpr_wr2_data;
  logic [7:0] space_state_reg, mem_req_space, fpr_wr_index, fpr_wr2_index;
  logic [2:0] first_source_extension, second_source_extension, third_source_extension;
  logic [2:0] destination_extension;
  logic [3:0] lat;
  logic [1:0] mem_req_size, fpr_wr_size;
  logic mem_req_valid, mem_req_priv, mem_req_phys, mem_req_little;
  logic mem_resp_valid, mem_resp_error, fpr_wr_en, fpr_wr2_en;
  fald_trap_e trap_code;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  fald_decode fald_decode_i (.*);
  fald_mem_model fald_mem_model_i (.*);
  always #10 sys_clk = ~sys_clk;
  // hang guard, far above the fewer than 100 cycles needed
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // rd 4, source index 1
  function automatic logic [31:0] mk(input logic [5:0] s, input logic i, input logic [12:0] f);
    return {FALD_OP_MEM, 5'h04, s, 5'h01, i, f};
  endfunction : mk
  // offer a word for one cycle; return inside the answer cycle
  task automatic go(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b);
    @(posedge sys_clk);
    issue_valid <= 1'b1;
    issue_instr <= w;
    first_source_value <= a;
    second_source_value <= b;
    @(posedge sys_clk);
    issue_valid <= 1'b0;
    #1;
  endtask : go
  // bounded wait for write-back or trap
  task automatic wait_done();
    int k;
    for (k = 0; k < 20; k++)
    begin
      @(posedge sys_clk);
      #1;
      if (fpr_wr_en === 1'b1 || trap_valid === 1'b1)
        break;
    end
  endtask : wait_done
  task automatic trap(input logic [31:0] w, input logic [63:0] a, input fald_trap_e c);
    go(w, a, 64'h0);
    check({trap_valid, mem_req_valid, trap_code}, {2'h2, c});
  endtask : trap
  task automatic t_single();
    check(issue_ready, 1'b1);
    go(mk(FALD_SUB_SINGLE, 1'b0, {8'h80, 5'h02}), 64'h100, 64'h4);
    check({mem_req_valid, mem_req_priv}, 2'h2);
    check(mem_req_addr, 64'h104);
    check(mem_req_space, 8'h80);
    check(mem_req_size, FALD_SIZE_WORD);
    wait_done();
    check({fpr_wr_en, fpr_wr_index}, 9'h104);
    check(fpr_wr_data, 64'h115);
    check(fpr_wr_size, FALD_SIZE_WORD);
    $display("single load done");
  endtask : t_single
  task automatic t_dbl_err();
    // side inputs change on a rising edge, like the issue word
    @(posedge sys_clk);
    space_state_reg <= 8'h10;
    lat <= 4'h5;
    err <= 1'b1;
    go(mk(FALD_SUB_DOUBLE, 1'b1, 13'h1FF8), 64'h110, 64'h0);
    check(mem_req_addr, 64'h108);
    check(mem_req_space, 8'h10);
    check({mem_req_priv, mem_req_size}, {1'b1, FALD_SIZE_DWORD});
    wait_done();
    check({fpr_wr_en, trap_valid, trap_code}, {2'h1, FALD_TRAP_ACCESS_ERROR});
    @(posedge sys_clk);
    err <= 1'b0;
    lat <= 4'h0;
    $display("double error load done");
  endtask : t_dbl_err
  task automatic t_atomic();
    go(mk(FALD_SUB_DOUBLE, 1'b0, {8'h3C, 5'h00}), 64'h200, 64'h0);
    check({mem_req_size, mem_req_phys, mem_req_little}, 4'hB);
    wait_done();
    check({fpr_wr_en, fpr_wr2_en, fpr_wr_index, fpr_wr2_index}, 18'h30405);
    check(fpr_wr_data, 64'h211);
    check(fpr_wr2_data, ~64'h200);
    check(fpr_wr_size, FALD_SIZE_QWORD);
    $display("atomic quad load done");
  endtask : t_atomic
  task automatic t_traps();
    @(posedge sys_clk);
    float_status_enable <= 1'b0;
    supervisor_flag <= 1'b0;
    trap(mk(FALD_SUB_QUAD, 1'b0, 13'h0), 64'h0, FALD_TRAP_ILLEGAL_INSTR);
    trap(mk(FALD_SUB_SINGLE, 1'b0, 13'h0), 64'h2, FALD_TRAP_UNIT_OFF);
    @(posedge sys_clk);
    float_status_enable <= 1'b1;
    state_float_enable <= 1'b0;
    trap(mk(FALD_SUB_DOUBLE, 1'b0, 13'h0), 64'h0, FALD_TRAP_UNIT_OFF);
    @(posedge sys_clk);
    state_float_enable <= 1'b1;
    trap(mk(FALD_SUB_SINGLE, 1'b0, 13'h0), 64'h0, FALD_TRAP_PRIV_ACTION);
    @(posedge sys_clk);
    supervisor_flag <= 1'b1;
    trap(mk(FALD_SUB_SINGLE, 1'b0, 13'h0), 64'h2, FALD_TRAP_MISALIGN);
    trap(mk(FALD_SUB_DOUBLE, 1'b0, 13'h0), 64'h4, FALD_TRAP_DOUBLE_MISALIGN);
    trap(mk(FALD_SUB_DOUBLE, 1'b0, {8'h34, 5'h0}), 64'h208, FALD_TRAP_MISALIGN);
    @(posedge sys_clk);
    extension_prefix_valid <= 1'b1;
    first_source_extension <= 3'h2;
    trap(mk(FALD_SUB_SINGLE, 1'b0, 13'h0), 64'h0, FALD_TRAP_ILLEGAL_ACTION);
    @(posedge sys_clk);
    first_source_extension <= 3'h0;
    third_source_extension <= 3'h4;
    trap(mk(FALD_SUB_DOUBLE, 1'b0, 13'h0), 64'h0, FALD_TRAP_ILLEGAL_ACTION);
    @(posedge sys_clk);
    third_source_extension <= 3'h0;
    extension_vector_bit <= 1'b1;
    destination_extension <= 3'h4;
    trap(mk(FALD_SUB_DOUBLE, 1'b0, 13'h0), 64'h0, FALD_TRAP_ILLEGAL_ACTION);
    @(posedge sys_clk);
    destination_extension <= 3'h0;
    trap(mk(FALD_SUB_DOUBLE, 1'b0, 13'h0), 64'h4, FALD_TRAP_MISALIGN);
    $display("trap cases done");
  endtask : t_traps
  initial
  begin
    {issue_valid, extension_prefix_valid, extension_vector_bit, err} = 4'h0;
    {supervisor_flag, float_status_enable, state_float_enable} = 3'h7;
    {issue_instr, first_source_value, second_source_value} = '0;
    {space_state_reg, lat, first_source_extension, second_source_extension} = '0;
    {third_source_extension, destination_extension} = '0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_single();
    t_dbl_err();
    t_atomic();
    t_traps();
    give_verdict();
  end
endmodule : test_fald_decode
